// File: src/serial_comm_pkg.sv
`default_nettype none
package serial_comm_pkg;
	// Host bus register selects
	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_MODE = 2'h2;
	localparam logic [1:0] SEL_COMMAND = 2'h3;
	// Mode register fields (second_mode_register)
	localparam int MODE_RATE_LSB = 0;
	localparam int MODE_INT_GEN_BIT = 4;
	localparam int MODE_SYNC_BIT = 5;
	// Command register fields
	localparam int CMD_TX_EN_BIT = 0;
	localparam int CMD_RX_EN_BIT = 2;
	// Status register fields
	localparam int STAT_TX_HOLD_BIT = 0;
	localparam int STAT_RX_HOLD_BIT = 1;
	localparam int STAT_OVERRUN_BIT = 3;
	// Avalon register byte offsets
	localparam logic [3:0] AVS_IRQ_STATUS = 4'h0;
	localparam logic [3:0] AVS_IRQ_MASK = 4'h4;
	localparam logic [3:0] AVS_RATE_CFG = 4'h8;
	// Interrupt status bits
	localparam int IRQ_RX_CHAR = 0;
	localparam int IRQ_TX_FREE = 1;
	localparam int IRQ_OVERRUN = 2;
	localparam int IRQ_W = 3;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic RATE_SET_RST = 1'b0;
	// Sync mode runs the generator at one-times: extra divide by 16
	localparam int SYNC_DIV_SHIFT = 4;
	localparam int DIV_W = 17;

	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} avs_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} char_t;

	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_RUN = 2'b01
	} div_state_t;
endpackage
`default_nettype wire

// File: src/serial_comm_host_port_brg.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`default_nettype none
module serial_comm_host_port_brg (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_master_reset,
	input wire logic i_chip_enable_n,
	input wire logic i_rw_write,
	input wire logic [1:0] i_register_select_lines,
	input wire logic [7:0] i_host_data_lines,
	output logic [7:0] o_host_data_lines,
	output logic o_host_data_lines_oe,
	output logic o_tx_holding_free_n,
	output logic o_tx_holding_free_n_oe,
	output logic o_rx_char_available_n,
	output logic o_rx_char_available_n_oe,
	input wire logic i_rate_reference_clock,
	output logic o_tx_bit_clock,
	output logic o_rx_bit_clock,
	input wire serial_comm_pkg::char_t i_rx_char,
	output serial_comm_pkg::char_t o_tx_char,
	input wire logic i_tx_char_taken,
	input wire serial_comm_pkg::avs_req_t i_avs,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq
);
	import serial_comm_pkg::*;

	logic [7:0] mode_reg, mode_next;
	logic [7:0] command_reg, command_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] tx_holding_register, tx_hold_next;
	logic [7:0] rx_holding_register, rx_hold_next;
	logic access_prev_reg;
	logic [7:0] bus_out_reg;
	logic bus_oe_reg;
	logic [IRQ_W-1:0] irq_status_reg, irq_status_next;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic rate_set_reg;
	logic wait_reg;
	logic [31:0] avs_rdata_reg;
	logic irq_reg;
	logic ref_prev_reg;
	logic [5:0] rate_code_prev_reg;
	logic [DIV_W-1:0] cnt_reg, cnt_next;
	logic tx_clk_reg, rx_clk_reg;
	div_state_t div_state_reg, div_state_next;

	// Table of divisors for both selectable rate sets
	function automatic logic [12:0] rate_divisor(input logic third_set, input logic [3:0] code);
		logic [12:0] d;
		d = 13'h0010;
		if (!third_set)
		begin
			case (code)
				4'h0: d = 13'h1A60;
				4'h1: d = 13'h1800;
				4'h2: d = 13'h1000;
				4'h3: d = 13'h0AE9;
				4'h4: d = 13'h08EC;
				4'h5: d = 13'h0800;
				4'h6: d = 13'h0400;
				4'h7: d = 13'h0200;
				4'h8: d = 13'h0100;
				4'h9: d = 13'h00AB;
				4'hA: d = 13'h009A;
				4'hB: d = 13'h0080;
				4'hC: d = 13'h0040;
				4'hD: d = 13'h0020;
				4'hE: d = 13'h0010;
				default: d = 13'h0008;
			endcase
		end
		else
		begin
			case (code)
				4'h0: d = 13'h18C0;
				4'h1: d = 13'h1080;
				4'h2: d = 13'h0B40;
				4'h3: d = 13'h0933;
				4'h4: d = 13'h0840;
				4'h5: d = 13'h0420;
				4'h6: d = 13'h0210;
				4'h7: d = 13'h0108;
				4'h8: d = 13'h00B0;
				4'h9: d = 13'h009E;
				4'hA: d = 13'h0084;
				4'hB: d = 13'h0058;
				4'hC: d = 13'h0042;
				4'hD: d = 13'h002C;
				4'hE: d = 13'h0021;
				default: d = 13'h0010;
			endcase
		end
		return d;
	endfunction

	// Host bus decode; one access is taken on the first cycle chip enable is low
	wire access_now = !i_chip_enable_n;
	wire access_start = access_now && !access_prev_reg;
	wire host_write = access_start && i_rw_write;
	wire host_read = access_start && !i_rw_write;
	wire sel_data = i_register_select_lines == SEL_DATA;
	wire sel_mode = i_register_select_lines == SEL_MODE;
	wire sel_command = i_register_select_lines == SEL_COMMAND;
	wire tx_en = command_reg[CMD_TX_EN_BIT];
	wire rx_en = command_reg[CMD_RX_EN_BIT];
	wire sync_mode = mode_reg[MODE_SYNC_BIT];
	wire [3:0] rate_code = mode_reg[MODE_RATE_LSB +: 4];

	// Read mux; positive true levels straight from the registers
	logic [7:0] read_mux;
	always_comb
	begin
		case (i_register_select_lines)
			SEL_DATA: read_mux = rx_holding_register;
			SEL_STATUS: read_mux = status_reg;
			SEL_MODE: read_mux = mode_reg;
			SEL_COMMAND: read_mux = command_reg;
			default: read_mux = 8'h00;
		endcase
	end

	// Holding registers and control words
	wire rx_arrive = i_rx_char.valid && rx_en;
	wire rx_read = host_read && sel_data;
	wire tx_load = host_write && sel_data;
	wire tx_free_now = tx_en && !o_tx_char.valid;
	assign mode_next = (host_write && sel_mode) ? i_host_data_lines : mode_reg;
	assign command_next = (host_write && sel_command) ? i_host_data_lines : command_reg;
	assign tx_hold_next = tx_load ? i_host_data_lines : tx_holding_register;
	assign rx_hold_next = rx_arrive ? i_rx_char.data : rx_holding_register;

	// Status: an arriving character beats a read in the same cycle
	always_comb
	begin
		status_next = status_reg;
		status_next[STAT_TX_HOLD_BIT] = tx_free_now && !tx_load;
		if (rx_arrive)
			status_next[STAT_RX_HOLD_BIT] = 1'b1;
		else if (rx_read || !rx_en)
			status_next[STAT_RX_HOLD_BIT] = 1'b0;
		if (rx_arrive && status_reg[STAT_RX_HOLD_BIT] && !rx_read)
			status_next[STAT_OVERRUN_BIT] = 1'b1;
		else if (!rx_en)
			status_next[STAT_OVERRUN_BIT] = 1'b0;
	end

	// Registers cleared by master reset without waiting for the clock
	always_ff @(posedge i_core_clk or posedge i_master_reset)
	begin
		if (i_master_reset)
		begin
			mode_reg <= MODE_RST;
			command_reg <= CMD_RST;
			status_reg <= STATUS_RST;
			o_tx_char <= '0;
		end
		else if (!i_rst_n)
		begin
			mode_reg <= MODE_RST;
			command_reg <= CMD_RST;
			status_reg <= STATUS_RST;
			o_tx_char <= '0;
		end
		else
		begin
			mode_reg <= mode_next;
			command_reg <= command_next;
			status_reg <= status_next;
			if (tx_load)
				o_tx_char <= '{valid: 1'b1, data: i_host_data_lines};
			else if (i_tx_char_taken)
				o_tx_char.valid <= 1'b0;
		end
	end

	// Data registers and bus drive; drive lags chip enable by one cycle
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			tx_holding_register <= 8'h00;
			rx_holding_register <= 8'h00;
			access_prev_reg <= 1'b0;
			bus_out_reg <= 8'h00;
			bus_oe_reg <= 1'b0;
		end
		else
		begin
			tx_holding_register <= tx_hold_next;
			rx_holding_register <= rx_hold_next;
			access_prev_reg <= access_now;
			bus_out_reg <= read_mux;
			bus_oe_reg <= access_now && !i_rw_write;
		end
	end
	assign o_host_data_lines = bus_out_reg;
	assign o_host_data_lines_oe = bus_oe_reg;

	// Ready pins only ever pull low: level is a constant zero flop, enable carries state
	logic ready_low_reg;
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			ready_low_reg <= 1'b0;
		else
			ready_low_reg <= 1'b0;
	end
	assign o_tx_holding_free_n = ready_low_reg;
	assign o_rx_char_available_n = ready_low_reg;
	assign o_tx_holding_free_n_oe = status_reg[STAT_TX_HOLD_BIT];
	assign o_rx_char_available_n_oe = status_reg[STAT_RX_HOLD_BIT];

	// Avalon slave: one wait cycle, then answer; unmapped reads return zero
	wire avs_req = i_avs.read || i_avs.write;
	wire avs_wr = i_avs.write && !wait_reg;
	logic [31:0] avs_rmux;
	always_comb
	begin
		case (i_avs.address)
			AVS_IRQ_STATUS: avs_rmux = {29'h0, irq_status_reg};
			AVS_IRQ_MASK: avs_rmux = {29'h0, irq_mask_reg};
			AVS_RATE_CFG: avs_rmux = {31'h0, rate_set_reg};
			default: avs_rmux = 32'h00000000;
		endcase
	end

	// Interrupt events; a new event wins over a write-one clear
	wire [IRQ_W-1:0] irq_events = {status_next[STAT_OVERRUN_BIT] && !status_reg[STAT_OVERRUN_BIT],
		status_next[STAT_TX_HOLD_BIT] && !status_reg[STAT_TX_HOLD_BIT], rx_arrive};
	wire [IRQ_W-1:0] irq_clear = (avs_wr && i_avs.address == AVS_IRQ_STATUS) ?
		i_avs.writedata[IRQ_W-1:0] : 3'h0;
	assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n || i_master_reset)
		begin
			irq_status_reg <= 3'h0;
			irq_mask_reg <= IRQ_MASK_RST;
			rate_set_reg <= RATE_SET_RST;
			wait_reg <= 1'b1;
			avs_rdata_reg <= 32'h00000000;
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_status_reg <= irq_status_next;
			if (avs_wr && i_avs.address == AVS_IRQ_MASK)
				irq_mask_reg <= i_avs.writedata[IRQ_W-1:0];
			if (avs_wr && i_avs.address == AVS_RATE_CFG)
				rate_set_reg <= i_avs.writedata[0];
			wait_reg <= !(avs_req && wait_reg);
			avs_rdata_reg <= avs_rmux;
			irq_reg <= |(irq_status_next & irq_mask_reg);
		end
	end
	assign o_avs_waitrequest = wait_reg;
	assign o_avs_readdata = avs_rdata_reg;
	assign o_irq = irq_reg;

	// Rate divider: counts reference edges; sync mode stretches to one-times
	wire [12:0] base_div = rate_divisor(rate_set_reg, rate_code);
	wire [DIV_W-1:0] div_eff = sync_mode ? {base_div, {SYNC_DIV_SHIFT{1'b0}}}
		: {{SYNC_DIV_SHIFT{1'b0}}, base_div};
	wire [DIV_W-1:0] div_half = {1'b0, div_eff[DIV_W-1:1]};
	wire gen_on = mode_reg[MODE_INT_GEN_BIT];
	wire ref_rise = i_rate_reference_clock && !ref_prev_reg;
	// Set or sync changes also move the divisor; a stale count could exceed a smaller one
	wire code_changed = {rate_set_reg, sync_mode, rate_code} != rate_code_prev_reg;

	always_comb
	begin
		div_state_next = div_state_reg;
		cnt_next = cnt_reg;
		case (div_state_reg)
			DIV_IDLE:
			begin
				cnt_next = '0;
				if (gen_on)
					div_state_next = DIV_RUN;
			end
			DIV_RUN:
			begin
				if (!gen_on)
				begin
					div_state_next = DIV_IDLE;
					cnt_next = '0;
				end
				else if (code_changed)
					cnt_next = '0;
				else if (ref_rise)
					cnt_next = (cnt_reg >= div_eff - 1'b1) ? '0 : cnt_reg + 1'b1;
			end
			default:
			begin
				div_state_next = DIV_IDLE;
				cnt_next = '0;
			end
		endcase
	end

	// Clock outputs high for the first half of each divide period; the receive clock stays low in sync mode
	always_ff @(posedge i_core_clk or posedge i_master_reset)
	begin
		if (i_master_reset)
		begin
			div_state_reg <= DIV_IDLE;
			cnt_reg <= '0;
			ref_prev_reg <= 1'b0;
			rate_code_prev_reg <= 6'h00;
			tx_clk_reg <= 1'b0;
			rx_clk_reg <= 1'b0;
		end
		else if (!i_rst_n)
		begin
			div_state_reg <= DIV_IDLE;
			cnt_reg <= '0;
			ref_prev_reg <= 1'b0;
			rate_code_prev_reg <= 6'h00;
			tx_clk_reg <= 1'b0;
			rx_clk_reg <= 1'b0;
		end
		else
		begin
			div_state_reg <= div_state_next;
			cnt_reg <= cnt_next;
			ref_prev_reg <= i_rate_reference_clock;
			rate_code_prev_reg <= {rate_set_reg, sync_mode, rate_code};
			tx_clk_reg <= (div_state_next == DIV_RUN) && (cnt_next < div_half);
			rx_clk_reg <= (div_state_next == DIV_RUN) && !sync_mode
				&& (cnt_next < div_half);
		end
	end
	assign o_tx_bit_clock = tx_clk_reg;
	assign o_rx_bit_clock = rx_clk_reg;

	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n || i_master_reset);

	sequence s_data_load;
		!i_chip_enable_n && !access_prev_reg && i_rw_write && sel_data;
	endsequence
	sequence s_char_in;
		i_rx_char.valid && rx_en;
	endsequence

	a_tx_load_busy: assert property (s_data_load |=> !status_reg[STAT_TX_HOLD_BIT]
		##0 !o_tx_holding_free_n_oe)
		else $error("tx ready still asserted after load");
	a_rx_char_flag: assert property (s_char_in |=> status_reg[STAT_RX_HOLD_BIT]
		&& o_rx_char_available_n_oe && rx_holding_register == $past(i_rx_char.data))
		else $error("received char not flagged");
	a_rx_read_clear: assert property (!i_chip_enable_n && !access_prev_reg && !i_rw_write
		&& sel_data && !i_rx_char.valid |=> !o_rx_char_available_n_oe)
		else $error("rx ready not released on read");
	a_rx_disable_clear: assert property (!rx_en |=> !status_reg[STAT_RX_HOLD_BIT])
		else $error("rx ready held while receiver off");
	a_bus_release: assert property (i_chip_enable_n |=> !o_host_data_lines_oe)
		else $error("data bus driven with chip disabled");
	a_bus_read: assert property (!i_chip_enable_n && !i_rw_write |=> o_host_data_lines_oe
		&& o_host_data_lines == $past(read_mux))
		else $error("read data not driven");
	a_mode_write: assert property (!i_chip_enable_n && !access_prev_reg && i_rw_write
		&& sel_mode |=> mode_reg == $past(i_host_data_lines))
		else $error("mode write lost");
	a_div_restart: assert property (div_state_reg == DIV_RUN && code_changed
		|=> cnt_reg == '0)
		else $error("divider not restarted on code change");
	a_div_bound: assert property (div_state_reg == DIV_RUN && !code_changed
		|-> cnt_reg < div_eff)
		else $error("divider count beyond divisor");
	a_sync_rx_quiet: assert property (sync_mode ##1 sync_mode |-> !o_rx_bit_clock)
		else $error("rx clock driven in sync mode");
	a_idle_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_master_reset |-> mode_reg == MODE_RST && command_reg == CMD_RST
		&& status_reg == STATUS_RST)
		else $error("master reset did not clear registers");
	a_avs_answer: assert property (avs_req && wait_reg |=> !wait_reg ##1 wait_reg)
		else $error("avalon answer timing wrong");
endmodule
`default_nettype wire

// File: tb/host_cpu_model.sv
`default_nettype none
// Host processor on the 8-bit bus; it drives the bus only while writing
module host_cpu_model (
	input wire logic i_clk,
	input wire logic [7:0] i_dev_data,
	input wire logic i_dev_oe,
	output logic o_ce_n,
	output logic o_rw,
	output logic [1:0] o_sel,
	output logic [7:0] o_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv = 1'b0;
	logic [7:0] wdat = 8'h00;
	logic [7:0] last = 8'h00;
	// Undriven bus shows the inverse of its last level, so a stale value never reads as good
	assign o_bus = i_dev_oe ? i_dev_data : (drv ? wdat : ~last);
	always @(posedge i_clk) last <= o_bus;
	initial
	begin
		o_ce_n = 1'b1;
		o_rw = 1'b0;
		o_sel = 2'h0;
	end
	// One bus cycle: select held for three edges, then released for two
	task automatic access(input logic wr, input logic [1:0] s, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge i_clk);
		o_ce_n <= 1'b0;
		o_rw <= wr;
		o_sel <= s;
		drv <= wr;
		wdat <= wd;
		repeat (3) @(posedge i_clk);
		rd = o_bus;
		o_ce_n <= 1'b1;
		drv <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// File: tb/serial_comm_host_port_brg_tb_top.sv
`default_nettype none
module serial_comm_host_port_brg_tb_top;
	import serial_comm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mrst = 1'b0;
	logic ref_clk = 1'b0;
	logic taken = 1'b0;
	char_t rxc = '0;
	avs_req_t av = '0;
	logic ce_n, rw, dq_oe, txn, txn_oe, rxn, rxn_oe, txbc, rxbc, wreq, irq;
	logic [1:0] sel;
	logic [7:0] bus, dq, b;
	char_t tx_bit_clock;
	logic [31:0] rdata, r;
	int err_total = 0;
	int samples_checked = 0;
	int n, i;
	logic [7:0] md [6] = '{8'h1F, 8'h10, 8'h1E, 8'h1F, 8'h10, 8'h3F};
	int st [6] = '{0, 0, 0, 1, 1, 1};
	int dv [6] = '{16, 13504, 32, 32, 12672, 512};
	// Reference toggles every core cycle: one rising edge per two cycles
	always #2 clk = ~clk;
	always @(posedge clk) ref_clk <= ~ref_clk;
	serial_comm_host_port_brg uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_master_reset(mrst),
		.i_chip_enable_n(ce_n), .i_rw_write(rw), .i_register_select_lines(sel),
		.i_host_data_lines(bus), .o_host_data_lines(dq), .o_host_data_lines_oe(dq_oe),
		.o_tx_holding_free_n(txn), .o_tx_holding_free_n_oe(txn_oe),
		.o_rx_char_available_n(rxn), .o_rx_char_available_n_oe(rxn_oe),
		.i_rate_reference_clock(ref_clk), .o_tx_bit_clock(txbc), .o_rx_bit_clock(rxbc),
		.i_rx_char(rxc), .o_tx_char(tx_bit_clock), .i_tx_char_taken(taken), .i_avs(av),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_irq(irq));
	host_cpu_model host (.i_clk(clk), .i_dev_data(dq), .i_dev_oe(dq_oe), .o_ce_n(ce_n),
		.o_rw(rw), .o_sel(sel), .o_bus(bus));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic hw(input logic [1:0] s, input logic [7:0] d);
		logic [7:0] x;
		host.access(1'b1, s, d, x);
	endtask
	task automatic hr(input logic [1:0] s, output logic [7:0] d);
		host.access(1'b0, s, 8'h00, d);
	endtask
	// Avalon access: request held until waitrequest is sampled low; only the watchdog ends a hang
	task automatic avx(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		av <= '{read: ~wr, write: wr, address: a, writedata: d};
		do
		begin
			@(posedge clk);
		end
		while (wreq !== 1'b0);
		q = rdata;
		av <= '0;
	endtask
	// Cycles until the next low-to-high step of the transmit bit clock
	task automatic rise(output int c);
		logic p;
		c = 0;
		p = txbc;
		while (c < 15000)
		begin
			@(posedge clk);
			c++;
			if (p === 1'b0 && txbc === 1'b1)
				break;
			p = txbc;
		end
	endtask
	task automatic rx_pulse;
		@(posedge clk);
		rxc <= '{valid: 1'b1, data: 8'hA5};
		@(posedge clk);
		rxc <= '0;
		repeat (3) @(posedge clk);
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog sized well past the longest divider measurement
	initial
	begin
		#300000;
		err_total++;
		give_verdict;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Idle after reset, registers at their reset values
		hr(SEL_STATUS, b);
		chk(b, STATUS_RST);
		hr(SEL_MODE, b);
		chk(b, MODE_RST);
		chk(dq_oe, 1'b0);
		chk({tx_bit_clock.valid, txbc}, 2'b00);
		avx(1'b0, AVS_RATE_CFG, 32'h0, r);
		chk(r, {31'h0, RATE_SET_RST});
		avx(1'b0, AVS_IRQ_MASK, 32'h0, r);
		chk(r, {29'h0, IRQ_MASK_RST});
		avx(1'b1, 4'hC, 32'hFF, r);
		avx(1'b0, 4'hC, 32'h0, r);
		chk(r, 32'h0);
		// Program, read back, and try a refused status write
		hw(SEL_MODE, 8'h1F);
		hw(SEL_COMMAND, 8'h05);
		hr(SEL_MODE, b);
		chk(b, 8'h1F);
		hr(SEL_COMMAND, b);
		chk(b, 8'h05);
		hw(SEL_STATUS, 8'hFE);
		hr(SEL_STATUS, b);
		chk(b, 8'h01);
		chk({txn, txn_oe}, 2'b01);
		// Loading the holding register takes the ready pin away
		hw(SEL_DATA, 8'h3C);
		chk(tx_bit_clock, {1'b1, 8'h3C});
		chk(txn_oe, 1'b0);
		@(posedge clk);
		taken <= 1'b1;
		@(posedge clk);
		taken <= 1'b0;
		repeat (3) @(posedge clk);
		chk(txn_oe, 1'b1);
		// Character arrival, interrupt, holding read and clear
		avx(1'b1, AVS_IRQ_MASK, 32'h1, r);
		avx(1'b1, AVS_IRQ_STATUS, 32'h7, r);
		rx_pulse;
		chk({rxn, rxn_oe, irq}, 3'b011);
		hr(SEL_DATA, b);
		chk(b, 8'hA5);
		chk(rxn_oe, 1'b0);
		hr(SEL_STATUS, b);
		chk(b, 8'h01);
		avx(1'b0, AVS_IRQ_STATUS, 32'h0, r);
		chk(r[0], 1'b1);
		avx(1'b1, AVS_IRQ_STATUS, 32'h1, r);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		// Receiver disable also drops the receive ready pin
		rx_pulse;
		hw(SEL_COMMAND, 8'h01);
		chk(rxn_oe, 1'b0);
		// Master reset clears at once, with no clock edge needed
		hw(SEL_DATA, 8'h77);
		@(posedge clk);
		mrst <= 1'b1;
		#1;
		chk(tx_bit_clock.valid, 1'b0);
		@(posedge clk);
		mrst <= 1'b0;
		@(posedge clk);
		hr(SEL_MODE, b);
		chk(b, 8'h00);
		hr(SEL_COMMAND, b);
		chk(b, 8'h00);
		// Divider periods for boundary codes of both rate sets and sync mode
		for (i = 0; i < 6; i++)
		begin
			avx(1'b1, AVS_RATE_CFG, 32'(st[i]), r);
			hw(SEL_MODE, md[i]);
			rise(n);
			rise(n);
			chk(n, dv[i]);
			chk(rxbc, txbc && !md[i][MODE_SYNC_BIT]);
		end
		chk(rxbc, 1'b0);
		give_verdict;
	end
endmodule
`default_nettype wire
